// ===== hdl/rbi_pkg.sv
// constants and types shared by the radio busy indicator design
// How it works
// - all-ones destination frames reach every channel listener
// - local address all-ones accepts every frame on channel
// - after power-up busy low during self-test
// - self-test done raises busy, mode pins apply
// - busy low for tx, rx output, self-test
// - buffered input split into radio packets
// - 512-byte buffer; short bursts never overflow
// - busy low until buffer handed to radio
// - busy may rise once last packet starts
// - started last packet leaves buffer empty again
// - pending serial output also holds busy low
// - self-test on power-on, reset command, sleep exit
// - any busy cause drives low; none drives high
// - mode pins ignored while busy is low, except at self-test start
// - pending mode switch done within 1 ms
// - mode change while idle takes effect directly
// - parameter reload holds busy low
// - two pins pick normal, wake, saving, sleep

package rbi_pkg;

	// clock and timing
	localparam int CLK_HZ         = 10_000_000;
	localparam int SELFTEST_US    = 20_000;
	localparam int SELFTEST_CYC   = SELFTEST_US * (CLK_HZ / 1_000_000);
	localparam int TX_IDLE_US     = 3_000;
	localparam int TX_IDLE_CYC    = TX_IDLE_US * (CLK_HZ / 1_000_000);

	// buffer and packets
	localparam int BUF_DEPTH      = 512;
	localparam int BYTE_W         = 8;
	localparam int LVL_W          = 10;
	localparam logic [LVL_W-1:0] PKT_BYTES = 10'h03A;

	// addressing
	localparam logic [15:0] ADDR_ALL = 16'hFFFF;

	// operating modes, high pin then low pin
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_WAKE   = 2'h1;
	localparam logic [1:0] MODE_SAVE   = 2'h2;
	localparam logic [1:0] MODE_SLEEP  = 2'h3;
	localparam logic [1:0] MODE_RESET  = 2'h0;

	// received frame header from the radio
	typedef struct packed {
		logic [15:0] dest;
		logic [7:0]  chan;
	} rbi_hdr_type;

	// local address configuration
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  chan;
	} rbi_cfg_type;

	// transmit path states
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT,
		TX_LOAD,
		TX_GO
	} rbi_tx_type;

endpackage

// ===== hdl/rbi_busy.sv
// busy indicator, transmit buffer, packet loader and mode control
`timescale 1ns/1ps
`default_nettype none

// byte buffer between serial input and radio loader
module rbi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 512,
	parameter int LW    = 10
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	// fill level
	output logic      [LW-1:0]    level
);
	// count is wider than the pointers so full and empty differ
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [LW-1:0]    cnt_q;
	wire              push;
	wire              pop;

	// handshakes on both sides
	assign in_ready  = (cnt_q != LW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_q];
	assign level     = cnt_q;

	// storage has no reset; pointers guard it
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers and occupancy
	// pointers wrap by themselves, the depth being a power of two
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + LW'(push) - LW'(pop);
		end
	end
endmodule

// top of the busy indicator
module rbi_busy #(
	parameter int SELFTEST_CYC = rbi_pkg::SELFTEST_CYC,
	parameter int TX_IDLE_CYC  = rbi_pkg::TX_IDLE_CYC
) (
	// clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 NRST,
	// serial input bytes from the host
	input  wire logic                 RX_BYTE_VALID,
	input  wire logic [7:0]           RX_BYTE,
	output logic                      RX_BYTE_READY,
	// bytes loaded into the radio
	output logic                      RADIO_BYTE_VALID,
	output logic      [7:0]           RADIO_BYTE,
	input  wire logic                 RADIO_BYTE_READY,
	output logic                      RADIO_TX_GO,
	// received frame headers
	input  wire logic                 FRAME_VALID,
	input  wire rbi_pkg::rbi_hdr_type FRAME_HDR,
	input  wire rbi_pkg::rbi_cfg_type CFG,
	output logic                      FRAME_ACCEPT,
	// serial output still draining
	input  wire logic                 SER_OUT_PENDING,
	// control events and mode pins
	input  wire logic                 RESET_CMD,
	input  wire logic                 MODE_SELECT_LOW,
	input  wire logic                 MODE_SELECT_HIGH,
	// status
	output logic      [1:0]           MODE,
	output logic                      PARAM_RELOAD,
	output logic                      AUX_OUT,
	output logic                      AUX_OE
);
	localparam int LW = rbi_pkg::LVL_W;

	rbi_pkg::rbi_tx_type tx_q;
	rbi_pkg::rbi_tx_type tx_d;
	logic [31:0]   st_cnt_q;
	logic          st_q;
	logic [31:0]   idle_q;
	logic [LW-1:0] pk_q;
	logic          rdy_q;
	logic          rv_q;
	logic [7:0]    rb_q;
	logic          go_q;
	logic          acc_q;
	logic [1:0]    mode_q;
	logic          aux_q;
	logic          oe_q;

	wire           f_in_ready;
	wire           f_out_valid;
	wire  [7:0]    f_out_data;
	wire  [LW-1:0] f_level;
	wire           f_pop;
	wire           push;
	wire           slot_free;
	wire           pkt_full;
	wire           timed_out;
	wire           load_done;
	wire           tx_busy;
	wire           busy;
	wire  [1:0]    pins;
	wire           mode_take;
	wire           sleep_exit;
	wire           st_start;
	wire           chan_ok;
	wire           addr_ok;

	// transmit buffer, 512 bytes deep
	rbi_fifo #(
		.WIDTH (rbi_pkg::BYTE_W),
		.DEPTH (rbi_pkg::BUF_DEPTH),
		.LW    (LW)
	) u_buf (
		.clk       (REF_CLK),
		.nrst      (NRST),
		.in_valid  (push),
		.in_ready  (f_in_ready),
		.in_data   (RX_BYTE),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	// input accepted only on the registered ready
	assign push      = RX_BYTE_VALID && rdy_q && f_in_ready;
	assign slot_free = !rv_q || RADIO_BYTE_READY;
	assign f_pop     = (tx_q == rbi_pkg::TX_LOAD) && f_out_valid
		&& slot_free && (pk_q != rbi_pkg::PKT_BYTES);
	// a full packet loads at once; a short tail waits for the timeout
	assign pkt_full  = (f_level >= rbi_pkg::PKT_BYTES);
	assign timed_out = (idle_q >= 32'(TX_IDLE_CYC));
	// packet closes only once no byte is left in flight to the radio
	assign load_done = (pk_q == rbi_pkg::PKT_BYTES || !f_out_valid)
		&& slot_free && !f_pop;

	// transmit sequencing: wait, load, start
	always_comb begin
		tx_d = tx_q;
		unique case (tx_q)
			rbi_pkg::TX_IDLE: if (f_out_valid) tx_d = rbi_pkg::TX_WAIT;
			rbi_pkg::TX_WAIT: if (pkt_full || timed_out) begin
				tx_d = rbi_pkg::TX_LOAD;
			end
			rbi_pkg::TX_LOAD: if (load_done) tx_d = rbi_pkg::TX_GO;
			rbi_pkg::TX_GO: begin
				// go pulse ends the packet; bytes left in the buffer go back to wait, else idle
				tx_d = f_out_valid ? rbi_pkg::TX_WAIT
					: rbi_pkg::TX_IDLE;
			end
		endcase
	end

	// busy while data waits, loads or has yet to start
	// a started last packet no longer holds the pin low
	assign tx_busy = (tx_q != rbi_pkg::TX_IDLE) || f_out_valid;
	assign busy    = st_q || tx_busy || SER_OUT_PENDING;

	// mode pins, sampled while idle and at the start of each self-test
	assign pins       = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
	assign mode_take  = aux_q && !busy && (pins != mode_q);
	assign sleep_exit = mode_take && (mode_q == rbi_pkg::MODE_SLEEP);
	assign st_start   = RESET_CMD || sleep_exit;

	// address filter for received frames
	// all-ones on either side turns the address test into a pass
	assign chan_ok = (FRAME_HDR.chan == CFG.chan);
	assign addr_ok = (FRAME_HDR.dest == CFG.addr)
		|| (FRAME_HDR.dest == rbi_pkg::ADDR_ALL)
		|| (CFG.addr == rbi_pkg::ADDR_ALL);

	// transmit state, packet and idle counters
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			tx_q   <= rbi_pkg::TX_IDLE;
			idle_q <= '0;
			pk_q   <= '0;
		end else begin
			tx_q   <= tx_d;
			// a fresh byte restarts the end-of-input wait
			idle_q <= (push || tx_q != rbi_pkg::TX_WAIT) ? '0
				: idle_q + 32'h1;
			pk_q   <= (tx_q != rbi_pkg::TX_LOAD) ? '0
				: pk_q + LW'(f_pop);
		end
	end

	// radio byte stage and start pulse
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rv_q <= 1'b0;
			rb_q <= 8'h00;
			go_q <= 1'b0;
		end else begin
			if (f_pop) begin
				rv_q <= 1'b1;
				rb_q <= f_out_data;
			end else if (RADIO_BYTE_READY) begin
				rv_q <= 1'b0;
			end
			go_q <= (tx_q == rbi_pkg::TX_LOAD) && load_done;
		end
	end

	// two free slots keep one in-flight byte safe
	// ready is registered, so it lags the fill level by one cycle
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= (f_level < LW'(rbi_pkg::BUF_DEPTH - 2));
		end
	end

	// self-test and parameter reload timer
	// a restart wins over a counter that is just ending
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			st_q     <= 1'b1;
			st_cnt_q <= '0;
		end else if (st_start) begin
			st_q     <= 1'b1;
			st_cnt_q <= '0;
		end else if (st_q) begin
			st_cnt_q <= st_cnt_q + 32'h1;
			if (st_cnt_q >= 32'(SELFTEST_CYC - 1)) st_q <= 1'b0;
		end
	end

	// applied mode follows pins when idle and at the start of each self-test
	// leaving sleep restarts self-test through st_start
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			mode_q <= rbi_pkg::MODE_RESET;
		end else if (st_q && !st_start && st_cnt_q == '0) begin
			// configure from pins at start of each self-test
			mode_q <= pins;
		end else if (mode_take) begin
			mode_q <= pins;
		end
	end

	// busy pin: low wins over every idle cause
	// registered so the pin never glitches, at one cycle of latency
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			aux_q <= 1'b0;
			acc_q <= 1'b0;
		end else begin
			aux_q <= !busy;
			acc_q <= FRAME_VALID && chan_ok && addr_ok;
		end
	end

	// enable held high even in reset so the pin never floats
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			oe_q <= 1'b1;
		end else begin
			oe_q <= 1'b1;
		end
	end

	// outputs straight from flip-flops
	assign RX_BYTE_READY    = rdy_q;
	assign RADIO_BYTE_VALID = rv_q;
	assign RADIO_BYTE       = rb_q;
	assign RADIO_TX_GO      = go_q;
	assign FRAME_ACCEPT     = acc_q;
	assign MODE             = mode_q;
	assign PARAM_RELOAD     = st_q;
	assign AUX_OUT          = aux_q;
	// pin is always driven, never floated
	assign AUX_OE           = oe_q;
endmodule

`default_nettype wire

// ===== verification/rbi_busy_assertions.sv
// checker for busy pin, frame filter and mode rules
`timescale 1ns/1ps
`default_nettype none
module rbi_busy_assertions #(
	parameter int SELFTEST_CYC = 20,
	parameter int TX_IDLE_CYC  = 10
) (
	// clock and reset
	input wire logic			REF_CLK,
	input wire logic			NRST,
	// inputs seen
	input wire logic			RX_BYTE_VALID,
	input wire logic			RX_BYTE_READY,
	input wire logic			FRAME_VALID,
	input wire rbi_pkg::rbi_hdr_type	FRAME_HDR,
	input wire rbi_pkg::rbi_cfg_type	CFG,
	input wire logic			SER_OUT_PENDING,
	input wire logic			RESET_CMD,
	input wire logic			MODE_SELECT_LOW,
	input wire logic			MODE_SELECT_HIGH,
	// outputs watched
	input wire logic			FRAME_ACCEPT,
	input wire logic [1:0]			MODE,
	input wire logic			PARAM_RELOAD,
	input wire logic			AUX_OUT,
	input wire logic			AUX_OE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// frame match and idle decode
	wire logic hit = FRAME_HDR.chan == CFG.chan
		&& (FRAME_HDR.dest == CFG.addr || CFG.addr == rbi_pkg::ADDR_ALL
		|| FRAME_HDR.dest == rbi_pkg::ADDR_ALL);
	wire logic [1:0] pins = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
	wire logic idle = AUX_OUT && !SER_OUT_PENDING && !RX_BYTE_VALID
		&& !RESET_CMD && !PARAM_RELOAD;
	// short test value keeps eight cycles inside self-test
	sequence s_reload;
		(PARAM_RELOAD && !AUX_OUT) [*8];
	endsequence
	frame_take_a:
	assert property (FRAME_VALID && hit |=> FRAME_ACCEPT) else $error("frame lost");
	frame_skip_a:
	assert property (FRAME_VALID && !hit |=> !FRAME_ACCEPT) else $error("bad frame");
	busy_pend_a:
	assert property (SER_OUT_PENDING |=> !AUX_OUT) else $error("output idle");
	busy_byte_a:
	// the fill level moves one edge after the byte, the pin one more
	assert property (RX_BYTE_VALID && RX_BYTE_READY |=> ##1 !AUX_OUT)
		else $error("byte idle");
	reload_low_a:
	assert property (PARAM_RELOAD |=> !AUX_OUT) else $error("reload idle");
	selftest_run_a:
	assert property (RESET_CMD |=> PARAM_RELOAD ##1 s_reload)
		else $error("no self-test");
	pin_driven_a:
	assert property (AUX_OE) else $error("pin floats");
	mode_hold_a:
	assert property (!AUX_OUT && !PARAM_RELOAD && !RESET_CMD |=> $stable(MODE))
		else $error("mode moved");
	mode_apply_a:
	// a byte taken last cycle has not yet lowered the pin
	assert property (idle && !$past(RX_BYTE_VALID && RX_BYTE_READY)
		&& pins != MODE |=> MODE == pins) else $error("mode late");
	busy_rise_a:
	assert property ($rose(AUX_OUT) |-> !$past(SER_OUT_PENDING) && !PARAM_RELOAD)
		else $error("early rise");
endmodule
bind rbi_busy rbi_busy_assertions #(.SELFTEST_CYC(SELFTEST_CYC),
	.TX_IDLE_CYC(TX_IDLE_CYC)) u_rbi_busy_assertions (
	.REF_CLK          (REF_CLK),
	.NRST             (NRST),
	.RX_BYTE_VALID    (RX_BYTE_VALID),
	.RX_BYTE_READY    (RX_BYTE_READY),
	.FRAME_VALID      (FRAME_VALID),
	.FRAME_HDR        (FRAME_HDR),
	.CFG              (CFG),
	.SER_OUT_PENDING  (SER_OUT_PENDING),
	.RESET_CMD        (RESET_CMD),
	.MODE_SELECT_LOW  (MODE_SELECT_LOW),
	.MODE_SELECT_HIGH (MODE_SELECT_HIGH),
	.FRAME_ACCEPT     (FRAME_ACCEPT),
	.MODE             (MODE),
	.PARAM_RELOAD     (PARAM_RELOAD),
	.AUX_OUT          (AUX_OUT),
	.AUX_OE           (AUX_OE)
);
`default_nettype wire

// ===== verification/rbi_radio_model.sv
// radio side model taking loaded bytes with stalls
`timescale 1ns/1ps
`default_nettype none
module rbi_radio_model (
	// clock and control
	input wire logic	clk,
	input wire logic	hold,
	// loader handshake
	output logic		ready
);
	int s = 7;
	initial ready = 1'b0;
	// random stalls mimic a transceiver still busy on air
	always @(posedge clk) ready <= !hold && ($random(s) % 3 != 0);
endmodule
`default_nettype wire

// ===== verification/rbi_busy_tb.sv
// self-checking bench for the busy indicator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module rbi_busy_tb;
	logic				REF_CLK = 0, NRST = 0, hold = 0;
	logic				RX_BYTE_VALID = 0, FRAME_VALID = 0;
	logic				SER_OUT_PENDING = 0, RESET_CMD = 0;
	logic [7:0]			RX_BYTE = 8'h00, e8;
	logic [1:0]			pins = 2'h0, MODE;
	rbi_pkg::rbi_hdr_type		FRAME_HDR = '0, h;
	rbi_pkg::rbi_cfg_type		CFG = '0, c;
	logic				RX_BYTE_READY, RADIO_BYTE_VALID;
	logic				RADIO_BYTE_READY, RADIO_TX_GO, FRAME_ACCEPT;
	logic				PARAM_RELOAD, AUX_OUT, AUX_OE;
	logic [7:0]			RADIO_BYTE;
	logic [7:0]			q[$];
	int				seed = 94, fails, checks, cyc, gos, n, i;
	wire logic			MODE_SELECT_LOW = pins[0];
	wire logic			MODE_SELECT_HIGH = pins[1];
	rbi_busy #(.SELFTEST_CYC(20), .TX_IDLE_CYC(10)) u_rbi_busy (
		.REF_CLK          (REF_CLK),
		.NRST             (NRST),
		.RX_BYTE_VALID    (RX_BYTE_VALID),
		.RX_BYTE          (RX_BYTE),
		.RX_BYTE_READY    (RX_BYTE_READY),
		.RADIO_BYTE_VALID (RADIO_BYTE_VALID),
		.RADIO_BYTE       (RADIO_BYTE),
		.RADIO_BYTE_READY (RADIO_BYTE_READY),
		.RADIO_TX_GO      (RADIO_TX_GO),
		.FRAME_VALID      (FRAME_VALID),
		.FRAME_HDR        (FRAME_HDR),
		.CFG              (CFG),
		.FRAME_ACCEPT     (FRAME_ACCEPT),
		.SER_OUT_PENDING  (SER_OUT_PENDING),
		.RESET_CMD        (RESET_CMD),
		.MODE_SELECT_LOW  (MODE_SELECT_LOW),
		.MODE_SELECT_HIGH (MODE_SELECT_HIGH),
		.MODE             (MODE),
		.PARAM_RELOAD     (PARAM_RELOAD),
		.AUX_OUT          (AUX_OUT),
		.AUX_OE           (AUX_OE)
	);
	rbi_radio_model u_rbi_radio_model (.clk(REF_CLK), .hold(hold),
		.ready(RADIO_BYTE_READY));
	always #50 REF_CLK = ~REF_CLK;
	// order of bytes on the radio side, packet count, hang guard
	always @(posedge REF_CLK) begin
		if (NRST && RADIO_BYTE_VALID && RADIO_BYTE_READY) begin
			e8 = q.pop_front();
			`CHK(RADIO_BYTE, e8)
		end
		if (RADIO_TX_GO) gos++;
		if (++cyc == 30000) begin
			fails++;
			summarize();
		end
	end
	function automatic logic hit(rbi_pkg::rbi_hdr_type a, rbi_pkg::rbi_cfg_type b);
		return a.chan == b.chan && (a.dest == b.addr || &a.dest || &b.addr);
	endfunction
	task automatic wait_aux(int lim);
		for (int k = 0; k < lim && AUX_OUT !== 1'b1; k++) @(negedge REF_CLK);
		`CHK(AUX_OUT, 1'b1)
	endtask
	// offer bytes until cnt taken or lim edges pass
	task automatic send(int cnt, int lim);
		@(posedge REF_CLK);
		RX_BYTE_VALID <= 1;
		RX_BYTE <= 8'($random(seed));
		for (int k = 0; k < lim && n < cnt; k++) begin
			@(posedge REF_CLK);
			if (RX_BYTE_READY) begin
				q.push_back(RX_BYTE);
				n++;
				RX_BYTE <= 8'($random(seed));
			end
		end
		RX_BYTE_VALID <= 0;
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge REF_CLK);
		NRST <= 1;
		@(negedge REF_CLK);
		`CHK(AUX_OUT, 1'b0)
		`CHK(AUX_OE, 1'b1)
		wait_aux(40);
		`CHK(MODE, 2'h0)
		$display("power-up done");
		for (i = 0; i < 40; i++) begin
			c = {(i < 20) ? 16'($random(seed)) : 16'hFFFF, 8'h04};
			h = {(i % 3 == 0) ? 16'hFFFF : (i % 3 == 1) ? c.addr
				: 16'($random(seed)), (i % 5 == 0) ? 8'h05 : 8'h04};
			@(posedge REF_CLK);
			FRAME_VALID <= 1;
			FRAME_HDR <= h;
			CFG <= c;
			@(posedge REF_CLK);
			FRAME_VALID <= 0;
			@(negedge REF_CLK);
			`CHK(FRAME_ACCEPT, hit(h, c))
		end
		$display("frames done");
		hold <= 1;
		send(600, 560);
		@(negedge REF_CLK);
		`CHK(n >= 510 && n < 513, 1'b1)
		`CHK(RX_BYTE_READY, 1'b0)
		`CHK(AUX_OUT, 1'b0)
		hold <= 0;
		wait_aux(4000);
		`CHK(q.size(), 0)
		`CHK(gos, (n + 57) / 58)
		n = 0;
		send(3, 20);
		wait_aux(200);
		`CHK(n, 3)
		`CHK(gos, (512 + 57) / 58 + 1)
		$display("buffer done");
		for (i = 1; i < 5; i++) begin
			@(posedge REF_CLK);
			pins <= 2'(i);
			repeat (3) @(negedge REF_CLK);
			`CHK(MODE, 2'(i))
			if (i == 4) `CHK(PARAM_RELOAD, 1'b1)
			wait_aux(100);
		end
		@(posedge REF_CLK);
		SER_OUT_PENDING <= 1;
		@(posedge REF_CLK);
		pins <= 2'h2;
		repeat (5) @(negedge REF_CLK);
		`CHK(MODE, 2'h0)
		`CHK(AUX_OUT, 1'b0)
		@(posedge REF_CLK);
		SER_OUT_PENDING <= 0;
		wait_aux(5);
		repeat (2) @(negedge REF_CLK);
		`CHK(MODE, 2'h2)
		@(posedge REF_CLK);
		RESET_CMD <= 1;
		@(posedge REF_CLK);
		RESET_CMD <= 0;
		// registered pin drops one edge after the test restarts
		repeat (2) @(negedge REF_CLK);
		`CHK(PARAM_RELOAD, 1'b1)
		`CHK(AUX_OUT, 1'b0)
		wait_aux(100);
		$display("modes done");
		summarize();
	end
endmodule
`default_nettype wire
